// >>> io_routing_switch_control.sv
// Purpose: I/O routing for the third I/O of each group plus analog switches
// Assumes: Mode and control-mode bits arrive from registers outside
// Notes:   Outputs other than rdata follow the stored bits combinationally
//
// Functional notes
// - Control-mode clear: switch bit 0 opens, 1 closes the I/O switch.
// - Software mode: switch bit 0 drives low, 1 defers to group bits 5:4.
// - Hardware mode: switch bit 0 drives low, 1 hands pin to timer two.
// - Group register: four 2-bit fields, bits 1:0 first through 7:6 fourth.
// - Software group codes: low, high, float open, float closed.
// - Code 11 disables hysteresis; pin value still readable.
// - Hardware group codes: 00 sampling capacitor, 01 electrode, rest reserved.
// - Group fields act only on I/Os with control-mode set.
// - Fourth group field exists only on the low-density variant.
// - Hardware roles for first three fields only on low density.
// - First analog register: eight switches, 1 closes, reset zero.
// - Second register: bit 6 switch fourteen, bits 3:0 switches eleven-eight.
// - Switches nine to eleven reserved on the medium-density variant.
// - Third switch register resets to zero, all switches open.
// - Acquisition bit: 0 software managed, 1 hardware managed.
// - Control-mode set protects the I/O from the port registers.
`timescale 1ns/1ps
`include "io_routing_regs.svh"

module io_routing_switch_control #(
    parameter io_routing_pkg::density_e DENSITY = io_routing_pkg::DENSITY_LOW
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [7:0]                addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [7:0]                rdata,
    input  wire logic                      acquisition_mode_bit,
    input  wire logic [7:0]                control_mode_reg,
    output io_routing_pkg::pin_cfg_e       pin_cfg [8],
    output logic      [7:0]                io_switch_closed,
    output logic      [7:0]                hyst_disable,
    output io_routing_pkg::io_role_e       io_role [8],
    output logic      [7:0]                port_regs_blocked,
    output logic      [1:0]                group_mode_first,
    output logic      [1:0]                group_mode_second,
    output logic      [1:0]                group_mode_third,
    output logic      [1:0]                group_mode_fourth,
    output logic      [7:0]                analog_switch_bit,
    output logic                           switch_fourteen,
    output logic                           switch_eleven,
    output logic                           switch_ten,
    output logic                           switch_nine,
    output logic                           switch_eight
);
    import io_routing_pkg::*;

    logic [7:0] switch_ctrl_3_r;
    logic [7:0] io_group_ctrl_r;
    logic [7:0] analog_switch_ctrl_1_r;
    logic [7:0] analog_switch_ctrl_2_r;
    logic [7:0] asw2_mask;
    logic [7:0] group_mask;
    logic       low_density;

    function automatic logic [1:0] group_field(input logic [7:0] g,
                                               input int unsigned n);
        group_field = g[n*`GROUP_MODE_WIDTH +: `GROUP_MODE_WIDTH];
    endfunction

    assign low_density = (DENSITY == DENSITY_LOW);
    assign asw2_mask   = (DENSITY == DENSITY_MEDIUM) ?
                         `ASW2_MASK_MEDIUM : `ASW2_MASK_FULL;
    assign group_mask  = low_density ? 8'hFF : 8'h3F;

    io_routing_regfile u_regs (
        .clock                  (clock),
        .rst                    (rst),
        .addr                   (addr),
        .wdata                  (wdata),
        .wr_stb                 (wr_stb),
        .rd_stb                 (rd_stb),
        .asw2_mask              (asw2_mask),
        .group_mask             (group_mask),
        .rdata                  (rdata),
        .switch_ctrl_3_r        (switch_ctrl_3_r),
        .io_group_ctrl_r        (io_group_ctrl_r),
        .analog_switch_ctrl_1_r (analog_switch_ctrl_1_r),
        .analog_switch_ctrl_2_r (analog_switch_ctrl_2_r)
    );

    assign group_mode_first  = group_field(io_group_ctrl_r, 0);
    assign group_mode_second = group_field(io_group_ctrl_r, 1);
    assign group_mode_third  = group_field(io_group_ctrl_r, 2);
    assign group_mode_fourth = group_field(io_group_ctrl_r, 3);

    // Protected I/Os ignore the standard port registers
    assign port_regs_blocked = control_mode_reg;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_ch
            io_channel_decode u_dec (
                .channel_switch_bit   (switch_ctrl_3_r[i]),
                .control_mode         (control_mode_reg[i]),
                .acquisition_mode_bit (acquisition_mode_bit),
                .group_mode           (group_mode_third),
                .hw_roles_ok          (low_density),
                .pin_cfg              (pin_cfg[i]),
                .switch_closed        (io_switch_closed[i]),
                .hyst_disable         (hyst_disable[i]),
                .io_role              (io_role[i])
            );
        end
    endgenerate

    assign analog_switch_bit = analog_switch_ctrl_1_r;
    assign switch_fourteen = analog_switch_ctrl_2_r[`ASW2_SWITCH_FOURTEEN];
    assign switch_eleven   = analog_switch_ctrl_2_r[`ASW2_SWITCH_ELEVEN];
    assign switch_ten      = analog_switch_ctrl_2_r[`ASW2_SWITCH_TEN];
    assign switch_nine     = analog_switch_ctrl_2_r[`ASW2_SWITCH_NINE];
    assign switch_eight    = analog_switch_ctrl_2_r[`ASW2_SWITCH_EIGHT];
endmodule

// >>> io_routing_regs.svh
// Purpose: Offsets, field positions, reset values for the I/O routing block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Included by the control, decode and register file modules
`ifndef IO_ROUTING_REGS_SVH
`define IO_ROUTING_REGS_SVH

`define OFS_SWITCH_CTRL_3          8'h0B
`define OFS_IO_GROUP_CTRL          8'h0C
`define OFS_ANALOG_SWITCH_CTRL_1   8'h0D
`define OFS_ANALOG_SWITCH_CTRL_2   8'h0E

`define RST_SWITCH_CTRL_3          8'h00
`define RST_IO_GROUP_CTRL          8'hFF
`define RST_ANALOG_SWITCH_CTRL_1   8'h00
`define RST_ANALOG_SWITCH_CTRL_2   8'h00

`define ASW2_SWITCH_FOURTEEN       6
`define ASW2_SWITCH_ELEVEN         3
`define ASW2_SWITCH_TEN            2
`define ASW2_SWITCH_NINE           1
`define ASW2_SWITCH_EIGHT          0
`define ASW2_MASK_FULL             8'h4F
`define ASW2_MASK_MEDIUM           8'h41

`define GROUP_MODE_WIDTH           2
`define GROUP_MODE_FOURTH_LSB      6

`endif

// >>> io_routing_pkg.sv
// Purpose: Types shared by the I/O routing block
// Assumes: Constants come from io_routing_regs.svh
// Notes:   Pin configuration codes and density variants
package io_routing_pkg;

    typedef enum logic [2:0] {
        PIN_NORMAL      = 3'h0,
        PIN_PP_LOW      = 3'h1,
        PIN_PP_HIGH     = 3'h2,
        PIN_FLOAT_OPEN  = 3'h3,
        PIN_FLOAT_CLOSE = 3'h4,
        PIN_TIMER       = 3'h5
    } pin_cfg_e;

    typedef enum logic [1:0] {
        DENSITY_LOW    = 2'h0,
        DENSITY_MEDIUM = 2'h1,
        DENSITY_MPLUS  = 2'h2,
        DENSITY_HIGH   = 2'h3
    } density_e;

    typedef enum logic [1:0] {
        ROLE_NONE      = 2'h0,
        ROLE_SAMPLING  = 2'h1,
        ROLE_ELECTRODE = 2'h2
    } io_role_e;

endpackage

// >>> io_channel_decode.sv
// Purpose: Decode one routed I/O from its switch, mode and group bits
// Assumes: Pure combinational
// Notes:   Used for every I/O the block routes
`timescale 1ns/1ps
`include "io_routing_regs.svh"

module io_channel_decode (
    input  wire logic                      channel_switch_bit,
    input  wire logic                      control_mode,
    input  wire logic                      acquisition_mode_bit,
    input  wire logic [1:0]                group_mode,
    input  wire logic                      hw_roles_ok,
    output io_routing_pkg::pin_cfg_e       pin_cfg,
    output logic                           switch_closed,
    output logic                           hyst_disable,
    output io_routing_pkg::io_role_e       io_role
);
    import io_routing_pkg::*;

    always_comb begin
        pin_cfg       = PIN_NORMAL;
        switch_closed = 1'b0;
        hyst_disable  = 1'b0;
        io_role       = ROLE_NONE;
        if (!control_mode) begin
            switch_closed = channel_switch_bit;
        end else if (!channel_switch_bit) begin
            pin_cfg = PIN_PP_LOW;
        end else if (!acquisition_mode_bit) begin
            unique case (group_mode)
                2'b00: pin_cfg = PIN_PP_LOW;
                2'b01: pin_cfg = PIN_PP_HIGH;
                2'b10: pin_cfg = PIN_FLOAT_OPEN;
                2'b11: begin
                    pin_cfg       = PIN_FLOAT_CLOSE;
                    switch_closed = 1'b1;
                    hyst_disable  = 1'b1;
                end
            endcase
        end else begin
            pin_cfg = PIN_TIMER;
            if (hw_roles_ok) begin
                unique case (group_mode)
                    2'b00: io_role = ROLE_SAMPLING;
                    2'b01: io_role = ROLE_ELECTRODE;
                    2'b10,
                    2'b11: io_role = ROLE_NONE;
                endcase
            end
        end
    end
endmodule

// >>> io_routing_regfile.sv
// Purpose: The four routing registers behind the plain strobe port
// Assumes: Synchronous active-high reset
// Notes:   Read data valid the cycle after the read strobe only
`timescale 1ns/1ps
`include "io_routing_regs.svh"

module io_routing_regfile (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [7:0]                addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    input  wire logic [7:0]                asw2_mask,
    input  wire logic [7:0]                group_mask,
    output logic      [7:0]                rdata,
    output logic      [7:0]                switch_ctrl_3_r,
    output logic      [7:0]                io_group_ctrl_r,
    output logic      [7:0]                analog_switch_ctrl_1_r,
    output logic      [7:0]                analog_switch_ctrl_2_r
);
    always_ff @(posedge clock) begin
        if (rst) begin
            switch_ctrl_3_r <= `RST_SWITCH_CTRL_3;
        end else if (wr_stb && addr == `OFS_SWITCH_CTRL_3) begin
            switch_ctrl_3_r <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            io_group_ctrl_r <= `RST_IO_GROUP_CTRL;
        end else if (wr_stb && addr == `OFS_IO_GROUP_CTRL) begin
            io_group_ctrl_r <= wdata | ~group_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            analog_switch_ctrl_1_r <= `RST_ANALOG_SWITCH_CTRL_1;
        end else if (wr_stb && addr == `OFS_ANALOG_SWITCH_CTRL_1) begin
            analog_switch_ctrl_1_r <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            analog_switch_ctrl_2_r <= `RST_ANALOG_SWITCH_CTRL_2;
        end else if (wr_stb && addr == `OFS_ANALOG_SWITCH_CTRL_2) begin
            analog_switch_ctrl_2_r <= wdata & asw2_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            unique case (addr)
                `OFS_SWITCH_CTRL_3:        rdata <= switch_ctrl_3_r;
                `OFS_IO_GROUP_CTRL:        rdata <= io_group_ctrl_r;
                `OFS_ANALOG_SWITCH_CTRL_1: rdata <= analog_switch_ctrl_1_r;
                `OFS_ANALOG_SWITCH_CTRL_2: rdata <= analog_switch_ctrl_2_r;
                default:                   rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// >>> io_routing_switch_control_assertions.sv
// Purpose: Port checks for the I/O routing switch control
// Assumes: One clock, synchronous active-high reset
// Notes:   Keeps a shadow of the third switch register
`timescale 1ns/1ps
module io_routing_switch_control_assertions (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       acquisition_mode_bit,
    input wire logic [7:0] control_mode_reg,
    input wire logic [7:0] io_switch_closed,
    input wire logic [7:0] hyst_disable,
    input wire logic [7:0] port_regs_blocked,
    input wire logic [1:0] group_mode_first,
    input wire logic [1:0] group_mode_third,
    input wire logic [7:0] analog_switch_bit,
    input wire logic       switch_fourteen,
    input wire logic       switch_eight
);
    logic [7:0] sw3_r;
    logic       gm3_closed;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    assign gm3_closed = (group_mode_third == 2'h3);
    always_ff @(posedge clock) begin
        if (rst) begin
            sw3_r <= 8'h00;
        end else if (wr_stb && addr == 8'h0B) begin
            sw3_r <= wdata;
        end
    end
    property p_asw1;
        wr_stb && addr == 8'h0D |=> analog_switch_bit == $past(wdata);
    endproperty
    a_asw1: assert property (p_asw1) else $error("asw1 bad");
    property p_asw2;
        wr_stb && addr == 8'h0E |=> switch_fourteen == $past(wdata[6])
            && switch_eight == $past(wdata[0]);
    endproperty
    a_asw2: assert property (p_asw2) else $error("asw2 bad");
    property p_group;
        wr_stb && addr == 8'h0C |=> group_mode_first == $past(wdata[1:0])
            && group_mode_third == $past(wdata[5:4]);
    endproperty
    a_group: assert property (p_group) else $error("group bad");
    property p_direct;
        ((io_switch_closed ^ sw3_r) & ~control_mode_reg) == 8'h00;
    endproperty
    a_direct: assert property (p_direct) else $error("switch bad");
    property p_soft;
        !acquisition_mode_bit |-> ((io_switch_closed
            ^ (sw3_r & {8{gm3_closed}})) & control_mode_reg) == 8'h00;
    endproperty
    a_soft: assert property (p_soft) else $error("soft bad");
    property p_hyst;
        !acquisition_mode_bit |-> ((hyst_disable
            ^ (sw3_r & {8{gm3_closed}})) & control_mode_reg) == 8'h00;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hyst bad");
    property p_block;
        port_regs_blocked == control_mode_reg;
    endproperty
    a_block: assert property (p_block) else $error("block bad");
    property p_rd3;
        rd_stb && addr == 8'h0B |=> rdata == $past(sw3_r);
    endproperty
    a_rd3: assert property (p_rd3) else $error("read bad");
    property p_idle;
        !rd_stb |=> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("idle bad");
endmodule

bind io_routing_switch_control io_routing_switch_control_assertions u_chk (.*);

// >>> io_routing_switch_control_tb_top.sv
// Purpose: Self-checking bench for the I/O routing switch control
// Assumes: Default low-density build
// Notes:   Register port driven through tasks
`timescale 1ns/1ps
module io_routing_switch_control_tb_top;
    import io_routing_pkg::*;
    logic       clock = 0;
    logic       rst = 1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_stb = 0;
    logic       rd_stb = 0;
    logic       acquisition_mode_bit = 0;
    logic [7:0] control_mode_reg = 8'h00;
    logic [7:0] rdata, io_switch_closed, hyst_disable, port_regs_blocked;
    logic [7:0] analog_switch_bit;
    pin_cfg_e   pin_cfg [8];
    io_role_e   io_role [8];
    logic [1:0] group_mode_first, group_mode_second;
    logic [1:0] group_mode_third, group_mode_fourth;
    logic       switch_fourteen, switch_eleven, switch_ten;
    logic       switch_nine, switch_eight;
    logic [7:0] rdata_m;
    logic [1:0] gm4_m;
    logic       sw9_m;
    io_role_e   io_role_m [8];
    int         err_count = 0;
    int         tests_run = 0;
    int         cyc = 0;
    pin_cfg_e   sw_cfg [4] = '{PIN_PP_LOW, PIN_PP_HIGH, PIN_FLOAT_OPEN,
                               PIN_FLOAT_CLOSE};
    io_role_e   role_exp [4] = '{ROLE_SAMPLING, ROLE_ELECTRODE, ROLE_NONE,
                                 ROLE_NONE};

    io_routing_switch_control u_io_routing_switch_control (.*);

    // Medium-density build on the same bus
    io_routing_switch_control #(
        .DENSITY (DENSITY_MEDIUM)
    ) u_io_routing_switch_control_medium (
        .clock                (clock),
        .rst                  (rst),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_stb               (wr_stb),
        .rd_stb               (rd_stb),
        .rdata                (rdata_m),
        .acquisition_mode_bit (acquisition_mode_bit),
        .control_mode_reg     (control_mode_reg),
        .pin_cfg              (),
        .io_switch_closed     (),
        .hyst_disable         (),
        .io_role              (io_role_m),
        .port_regs_blocked    (),
        .group_mode_first     (),
        .group_mode_second    (),
        .group_mode_third     (),
        .group_mode_fourth    (gm4_m),
        .analog_switch_bit    (),
        .switch_fourteen      (),
        .switch_eleven        (),
        .switch_ten           (),
        .switch_nine          (sw9_m),
        .switch_eight         ()
    );

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic lvl(input logic acq, input logic [7:0] cm);
        @(posedge clock);
        acquisition_mode_bit <= acq;
        control_mode_reg     <= cm;
        #1;
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == 1000) begin
            err_count++;
            stop_test;
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(8'h0B, 8'h00);
        rd(8'h0C, 8'hFF);
        rd(8'h0D, 8'h00);
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h00);
        wr(8'h0D, 8'hA5);
        chk(analog_switch_bit, 8'hA5);
        rd(8'h0D, 8'hA5);
        wr(8'h0E, 8'h4F);
        rd(8'h0E, 8'h4F);
        chk(rdata_m, 8'h41);
        chk({3'h0, switch_fourteen, switch_eleven, switch_ten, switch_nine,
             switch_eight}, 8'h1F);
        chk({7'h00, sw9_m}, 8'h00);
        wr(8'h0C, 8'h1B);
        rd(8'h0C, 8'h1B);
        chk({group_mode_fourth, group_mode_third, group_mode_second,
             group_mode_first}, 8'h1B);
        lvl(1'b0, 8'h00);
        wr(8'h0B, 8'hA5);
        chk(io_switch_closed, 8'hA5);
        chk(8'(pin_cfg[0]), 8'(PIN_NORMAL));
        lvl(1'b0, 8'hFF);
        chk(port_regs_blocked, 8'hFF);
        for (int m = 0; m < 4; m++) begin
            wr(8'h0C, 8'(m << 4));
            chk(8'(pin_cfg[0]), 8'(sw_cfg[m]));
            chk(8'(pin_cfg[1]), 8'(PIN_PP_LOW));
            chk(io_switch_closed, m == 3 ? 8'hA5 : 8'h00);
            chk(hyst_disable, m == 3 ? 8'hA5 : 8'h00);
        end
        lvl(1'b1, 8'hFF);
        for (int m = 0; m < 4; m++) begin
            wr(8'h0C, 8'(m << 4));
            chk(8'(pin_cfg[0]), 8'(PIN_TIMER));
            chk(8'(pin_cfg[1]), 8'(PIN_PP_LOW));
            chk(8'(io_role[0]), 8'(role_exp[m]));
            chk(8'(io_role_m[0]), 8'(ROLE_NONE));
        end
        rd(8'h0C, 8'h30);
        chk(rdata_m, 8'hF0);
        chk({6'h00, gm4_m}, 8'h03);
        wr(8'h0D, 8'h00);
        chk(analog_switch_bit, 8'h00);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(8'h0B, 8'h00);
        stop_test;
    end
endmodule
